// >>> hw/tcs_ctrl.sv
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "tcs_defs.svh"
module tcs_ctrl #(
    // Time-read code of the unit; the default value is arbitrary.
    parameter logic [7:0] TIME_RD_CMD = 8'h00
) (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Command link to the unit.
    output logic             cmd_valid,
    output logic      [7:0]  cmd_byte,
    input  wire logic        cmd_ack,
    input  wire logic        rsp_valid,
    input  wire logic [7:0]  rsp_byte,
    // Supplies.
    output logic             low_voltage_supply_on,
    output logic             bias_on,
    input  wire logic        peer_unit_off
);
    tcs_pkg::tcs_state_t state_q;
    tcs_pkg::tcs_seq_t   seq_q;
    logic [4:0]  step_q;
    logic [2:0]  cnt_q;
    logic        cmd_valid_q;
    logic [7:0]  cmd_byte_q;
    logic [31:0] hrdata_q;
    logic        hready_q;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic        low_voltage_supply_q;
    logic        bias_q;
    logic        off_ok_q;
    logic        oper_q;
    logic        acc_q;
    logic        want_a_q;
    logic        want_b_q;
    logic        ready_q;
    logic [15:0] accumulation_time_q;
    logic [20:0] cfg_q [4];
    logic [5:0]  cal_q;
    logic [4:0]  mode_q;
    logic [15:0] fld_a_q;
    logic [23:0] fld_b_q;
    logic [23:0] fld_c_q;
    logic        rec_a_q;
    logic        rec_b_q;
    logic [2:0]  sc_q;
    logic [47:0] rsp_sh_q;
    logic        wr_ctrl;
    logic        start;
    logic        emerg;
    logic        newcyc;
    logic        sent;
    logic        rsp_last;
    logic        advance;
    logic        done;
    logic [8:0]  nxt;
    logic [47:0] rsp_full;
    logic        rsp_due;

    assign hrdata    = hrdata_q;
    assign hreadyout = hready_q;
    assign hresp     = 1'b0;
    assign cmd_valid = cmd_valid_q;
    assign cmd_byte  = cmd_byte_q;
    assign low_voltage_supply_on   = low_voltage_supply_q;
    assign bias_on   = bias_q;

    // Returns {end, byte} for a sequence step; arguments come from live registers.
    function automatic logic [8:0] fetch(input tcs_pkg::tcs_seq_t s, input logic [4:0] st);
        logic [1:0] ch;
        logic [4:0] sub;
        logic [7:0] b;
        logic       e;
        ch  = {s == tcs_pkg::SEQ_B_CFG, st >= `TCS_CHIP_STEP};
        sub = (st >= `TCS_CHIP_STEP) ? st - `TCS_CHIP_STEP : st;
        b   = 8'h00;
        e   = 1'b0;
        unique case (s)
            tcs_pkg::SEQ_A_CFG, tcs_pkg::SEQ_B_CFG: begin
                if (st < 5'h0C) begin
                    unique case (sub)
                        5'h00:   b = `TCS_CFG_BASE | {6'h00, ch};
                        5'h01:   b = {`TCS_GAIN_PFX, cfg_q[ch][20:16]};
                        5'h02:   b = cfg_q[ch][15:8];
                        5'h03:   b = cfg_q[ch][7:0];
                        5'h04:   b = `TCS_FILT_BASE + {4'h0, ch, 2'h0};
                        default: b = `TCS_CNT_BASE | {6'h00, ch};
                    endcase
                end else begin
                    unique case (st)
                        5'h0C:   b = `TCS_TIMER;
                        5'h0D:   b = accumulation_time_q[15:8];
                        5'h0E:   b = accumulation_time_q[7:0];
                        5'h0F:   b = ch[1] ? `TCS_SEL_B : `TCS_SEL_A;
                        5'h10:   b = `TCS_IRQCLR;
                        default: e = 1'b1;
                    endcase
                end
            end
            tcs_pkg::SEQ_B_PWR: begin
                unique case (st)
                    5'h00:   b = `TCS_PWR_B;
                    5'h01:   b = `TCS_DRV_B;
                    5'h02:   b = `TCS_EN_RST;
                    5'h03:   b = `TCS_DIGITAL;
                    5'h04:   b = `TCS_IRQCLR;
                    default: e = 1'b1;
                endcase
            end
            tcs_pkg::SEQ_A_RST, tcs_pkg::SEQ_B_RST: begin
                unique case (st)
                    5'h00:   b = `TCS_EN_RST;
                    5'h01:   b = `TCS_EN_OP;
                    5'h02:   b = `TCS_IRQCLR;
                    default: e = 1'b1;
                endcase
            end
            tcs_pkg::SEQ_OFF: begin
                unique case (st)
                    5'h00:   b = `TCS_EN_LOW;
                    5'h01:   b = `TCS_DRV_HZ;
                    5'h02:   b = `TCS_PWR_OFF;
                    default: e = 1'b1;
                endcase
            end
            tcs_pkg::SEQ_TIME: begin
                b = TIME_RD_CMD;
                e = (st != 5'h00);
            end
            tcs_pkg::SEQ_IRQ: begin
                b = `TCS_IRQCLR;
                e = (st != 5'h00);
            end
        endcase
        return {e, b};
    endfunction : fetch

    assign wr_ctrl  = wr_pend_q && (wr_addr_q == `TCS_A_CTRL);
    assign start    = wr_ctrl && hwdata[`TCS_C_START] && (state_q == tcs_pkg::ST_IDLE) && low_voltage_supply_q;
    assign emerg    = wr_ctrl && hwdata[`TCS_C_EMERG];
    assign newcyc   = wr_ctrl && hwdata[`TCS_C_NEWCYC];
    assign sent     = (state_q == tcs_pkg::ST_SEND) && cmd_ack;
    assign rsp_last = (state_q == tcs_pkg::ST_RESP) && rsp_valid && (cnt_q == 3'h1);
    // An answer is due only after the last byte of a sequence that reads the unit back.
    // Deciding by position, not by byte value, keeps argument bytes equal to a read code from stalling.
    assign rsp_due  = nxt[8] && (seq_q != tcs_pkg::SEQ_OFF);
    assign advance  = (sent && !rsp_due) || rsp_last;
    assign nxt      = fetch(seq_q, step_q + 5'h01);
    // A sequence that an emergency cuts short never counts as finished.
    assign done     = advance && nxt[8] && !emerg;
    assign rsp_full = {rsp_sh_q[39:0], rsp_byte};

    // Zero wait state slave: read data is taken in the address phase.
    // Only whole words are supported, so the transfer size is not looked at.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hready_q  <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q  <= 32'h0000_0000;
        end else begin
            hready_q  <= 1'b1;
            wr_pend_q <= hsel && htrans[1] && hready && hwrite;
            wr_addr_q <= {haddr[7:2], 2'h0};
            if (hsel && htrans[1] && hready && !hwrite) begin
                unique case ({haddr[7:2], 2'h0})
                    `TCS_A_CTRL: hrdata_q <= {28'h000_0000, off_ok_q, ready_q, low_voltage_supply_q,
                                              state_q != tcs_pkg::ST_IDLE};
                    `TCS_A_ACC:  hrdata_q <= {16'h0000, accumulation_time_q};
                    `TCS_A_CAL:  hrdata_q <= {26'h000_0000, cal_q};
                    `TCS_A_MODE: hrdata_q <= {27'h000_0000, mode_q};
                    `TCS_A_SW0:  hrdata_q <= {fld_a_q, fld_b_q[23:8]};
                    `TCS_A_SW1:  hrdata_q <= {fld_b_q[7:0], fld_c_q};
                    `TCS_A_SW2:  hrdata_q <= {sc_q, mode_q, 2'h0, cal_q, 16'h0000};
                    default: begin
                        if ((haddr[7:0] >= `TCS_A_CHIP0) && (haddr[7:0] < `TCS_A_CAL)) begin
                            hrdata_q <= {11'h000, cfg_q[haddr[3:2] - 2'h2]};
                        end else begin
                            hrdata_q <= 32'h0000_0000;
                        end
                    end
                endcase
            end
        end
    end

    // Configuration registers written by software.
    // Want bits are latched only with a start, so a write in mid-sequence cannot change them.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            accumulation_time_q <= 16'h0000;
            cal_q      <= 6'h00;
            mode_q     <= 5'h00;
            oper_q     <= 1'b0;
            acc_q      <= 1'b0;
            want_a_q   <= 1'b0;
            want_b_q   <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                cfg_q[i] <= 21'h00_0000;
            end
        end else if (wr_pend_q) begin
            if (wr_addr_q == `TCS_A_ACC) accumulation_time_q <= hwdata[15:0];
            if (wr_addr_q == `TCS_A_CAL) cal_q <= hwdata[5:0];
            if (wr_addr_q == `TCS_A_MODE) mode_q <= hwdata[4:0];
            if ((wr_addr_q >= `TCS_A_CHIP0) && (wr_addr_q < `TCS_A_CAL)) begin
                cfg_q[wr_addr_q[3:2] - 2'h2] <= hwdata[20:0];
            end
            if (wr_ctrl) begin
                oper_q <= hwdata[`TCS_C_OPER];
                acc_q  <= hwdata[`TCS_C_ACC];
                if (start) begin
                    want_a_q <= hwdata[`TCS_C_WANTA];
                    want_b_q <= hwdata[`TCS_C_WANTB];
                end
            end
        end
    end

    // Sequencer: one byte is offered at a time and held until acknowledged.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q     <= tcs_pkg::ST_IDLE;
            seq_q       <= tcs_pkg::SEQ_IRQ;
            step_q      <= 5'h00;
            cnt_q       <= 3'h0;
            cmd_valid_q <= 1'b0;
            cmd_byte_q  <= 8'h00;
        end else if (emerg) begin
            // Step and count are left as they are; the next start reloads the step, and the next answer wait reloads the count.
            state_q     <= tcs_pkg::ST_IDLE;
            cmd_valid_q <= 1'b0;
        end else begin
            unique case (state_q)
                tcs_pkg::ST_IDLE: begin
                    if (start) begin
                        seq_q       <= tcs_pkg::tcs_seq_t'(hwdata[2:0]);
                        step_q      <= 5'h00;
                        cmd_byte_q  <= 8'(fetch(tcs_pkg::tcs_seq_t'(hwdata[2:0]), 5'h00));
                        cmd_valid_q <= 1'b1;
                        state_q     <= tcs_pkg::ST_SEND;
                    end
                end
                tcs_pkg::ST_SEND: begin
                    if (sent && !advance) begin
                        cmd_valid_q <= 1'b0;
                        cnt_q       <= (seq_q == tcs_pkg::SEQ_TIME) ? `TCS_TIME_RSP : `TCS_IRQ_RSP;
                        state_q     <= tcs_pkg::ST_RESP;
                    end
                end
                tcs_pkg::ST_RESP: begin
                    if (rsp_valid) cnt_q <= cnt_q - 3'h1;
                end
                default: state_q <= tcs_pkg::ST_IDLE;
            endcase
            if (advance) begin
                step_q      <= step_q + 5'h01;
                cmd_byte_q  <= nxt[7:0];
                cmd_valid_q <= !nxt[8];
                state_q     <= nxt[8] ? tcs_pkg::ST_IDLE : tcs_pkg::ST_SEND;
            end
        end
    end

    // Answers: interrupt register high byte first, time stamp A bytes before B.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp_sh_q <= 48'h0000_0000_0000;
            fld_a_q  <= 16'h0000;
            fld_b_q  <= 24'h00_0000;
            fld_c_q  <= 24'h00_0000;
            rec_a_q  <= 1'b0;
            rec_b_q  <= 1'b0;
            sc_q     <= `TCS_SC_A;
        end else begin
            if (newcyc) begin
                fld_a_q <= 16'h0000;
                fld_b_q <= 24'h00_0000;
                fld_c_q <= 24'h00_0000;
                rec_a_q <= 1'b0;
                rec_b_q <= 1'b0;
            end
            if (sent && (cmd_byte_q == `TCS_SEL_A)) sc_q <= `TCS_SC_A;
            if (sent && (cmd_byte_q == `TCS_SEL_B)) sc_q <= `TCS_SC_B;
            if ((state_q == tcs_pkg::ST_RESP) && rsp_valid) rsp_sh_q <= rsp_full;
            if (rsp_last && (seq_q != tcs_pkg::SEQ_TIME)) begin
                fld_a_q <= oper_q ? (fld_a_q | rsp_full[15:0]) : rsp_full[15:0];
            end
            if (rsp_last && (seq_q == tcs_pkg::SEQ_TIME) && acc_q) begin
                if (want_a_q && !rec_a_q) begin
                    fld_b_q <= rsp_full[47:24];
                    rec_a_q <= 1'b1;
                end
                if (want_b_q && !rec_b_q) begin
                    fld_c_q <= rsp_full[23:0];
                    rec_b_q <= 1'b1;
                end
            end
        end
    end

    // Supplies and word-ready flag; with oper_q clear, a finishing sequence beats a same-cycle clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_voltage_supply_q   <= 1'b0;
            bias_q   <= 1'b1;
            off_ok_q <= 1'b0;
            ready_q  <= 1'b0;
        end else begin
            bias_q <= low_voltage_supply_q || !peer_unit_off;
            if (wr_ctrl && hwdata[`TCS_C_RDYCLR]) ready_q <= 1'b0;
            if (done && !oper_q) ready_q <= 1'b1;
            if (start) off_ok_q <= 1'b0;
            if (done && (seq_q == tcs_pkg::SEQ_OFF)) off_ok_q <= 1'b1;
            if (wr_ctrl && hwdata[`TCS_C_LVON]) low_voltage_supply_q <= 1'b1;
            if (wr_ctrl && hwdata[`TCS_C_LVOFF] && off_ok_q) low_voltage_supply_q <= 1'b0;
            if (emerg) low_voltage_supply_q <= 1'b0;
        end
    end

    // Checks sample on the bus clock and stay quiet while reset is held.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_cmd_hold_ack: assert property (cmd_valid_q && !cmd_ack && !emerg |=> cmd_valid_q && $stable(cmd_byte_q))
        else $error("command byte dropped before acknowledge");
    a_irq_answer_wait: assert property (sent && rsp_due && cmd_byte_q == `TCS_IRQCLR |=> !cmd_valid_q [*2])
        else $error("command sent before interrupt answer");
    a_next_byte_now: assert property (sent && !nxt[8] && !emerg |=> cmd_valid_q)
        else $error("next command byte not offered after acknowledge");
    a_cfg_first_arg: assert property (sent && cmd_byte_q[7:2] == 6'h24 && !emerg
        && (seq_q == tcs_pkg::SEQ_A_CFG || seq_q == tcs_pkg::SEQ_B_CFG) && (step_q == 5'h00 || step_q == `TCS_CHIP_STEP)
        |=> cmd_valid_q && cmd_byte_q[7:5] == `TCS_GAIN_PFX)
        else $error("config argument prefix wrong");
    a_bpwr_first_cmd: assert property (start && !emerg && hwdata[2:0] == 3'h0 |=> cmd_byte_q == `TCS_PWR_B)
        else $error("power-on sequence opened with wrong byte");
    a_reset_second: assert property (sent && cmd_byte_q == `TCS_EN_RST && seq_q == tcs_pkg::SEQ_A_RST && !emerg
        |=> cmd_byte_q == `TCS_EN_OP)
        else $error("reset sequence did not return to operational");
    a_off_last_cmd: assert property (sent && seq_q == tcs_pkg::SEQ_OFF && cmd_byte_q == `TCS_DRV_HZ && !emerg
        |=> cmd_byte_q == `TCS_PWR_OFF)
        else $error("power-off sequence order wrong");
    a_bias_stays_on: assert property (low_voltage_supply_q |=> bias_q)
        else $error("bias removed while supply on");
    a_emerg_silent: assert property (emerg |=> !low_voltage_supply_q && !cmd_valid_q ##1 bias_q == !peer_unit_off)
        else $error("emergency off did not act at once");
    a_low_voltage_supply_guard: assert property ($fell(low_voltage_supply_q) |-> $past(off_ok_q) || $past(emerg))
        else $error("supply removed before power-off sequence");
    a_irq_or_keep: assert property (oper_q && !newcyc |=> (fld_a_q & $past(fld_a_q)) == $past(fld_a_q))
        else $error("interrupt accumulation lost a bit");
    a_stamp_once: assert property (rec_a_q && !newcyc |=> $stable(fld_b_q))
        else $error("telescope A time stamp overwritten");
    a_word_ready: assert property (done && !oper_q |=> ready_q)
        else $error("status word not flagged after sequence");

    c_bpwr_done: cover property (done && seq_q == tcs_pkg::SEQ_B_PWR);
    c_acfg_done: cover property (done && seq_q == tcs_pkg::SEQ_A_CFG);
    c_stamp_a: cover property (rsp_last && seq_q == tcs_pkg::SEQ_TIME && want_a_q && !rec_a_q && acc_q);
    c_emergency: cover property (emerg && cmd_valid_q);
    c_off_done: cover property (done && seq_q == tcs_pkg::SEQ_OFF);
endmodule : tcs_ctrl

// >>> hw/tcs_defs.svh
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH
`define TCS_PWR_B     8'h41
`define TCS_DRV_B     8'h85
`define TCS_EN_RST    8'h89
`define TCS_EN_OP     8'h8B
`define TCS_EN_LOW    8'h88
`define TCS_DRV_HZ    8'h84
`define TCS_PWR_OFF   8'h40
`define TCS_DIGITAL   8'h8C
`define TCS_IRQCLR    8'h70
`define TCS_CFG_BASE  8'h90
`define TCS_FILT_BASE 8'h32
`define TCS_CNT_BASE  8'hA8
`define TCS_TIMER     8'hD0
`define TCS_SEL_A     8'h48
`define TCS_SEL_B     8'h4A
`define TCS_GAIN_PFX  3'h4
`define TCS_CHIP_STEP 5'h06
`define TCS_IRQ_RSP   3'h2
`define TCS_TIME_RSP  3'h6
`define TCS_SC_A      3'h0
`define TCS_SC_B      3'h4
`define TCS_A_CTRL    8'h00
`define TCS_A_ACC     8'h04
`define TCS_A_CHIP0   8'h08
`define TCS_A_CAL     8'h18
`define TCS_A_MODE    8'h1C
`define TCS_A_SW0     8'h20
`define TCS_A_SW1     8'h24
`define TCS_A_SW2     8'h28
`define TCS_C_START   3
`define TCS_C_EMERG   4
`define TCS_C_LVON    5
`define TCS_C_LVOFF   6
`define TCS_C_OPER    7
`define TCS_C_ACC     8
`define TCS_C_NEWCYC  9
`define TCS_C_RDYCLR  10
`define TCS_C_WANTA   11
`define TCS_C_WANTB   12
`endif

// >>> hw/tcs_pkg.sv
package tcs_pkg;
    typedef enum logic [2:0] {
        SEQ_B_PWR, SEQ_A_CFG, SEQ_B_CFG, SEQ_A_RST,
        SEQ_B_RST, SEQ_OFF, SEQ_TIME, SEQ_IRQ
    } tcs_seq_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_RESP} tcs_state_t;
endpackage : tcs_pkg

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    // The time-read code is arbitrary; nothing fixes it for the unit.
    localparam logic [7:0] TRD = 8'h5A;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cmd_valid, cmd_ack;
    logic        rsp_valid, low_voltage_supply_on, bias_on, peer_unit_off, arg_bad, rd_ph, fbv, fcv;
    logic [1:0]  htrans;
    logic [2:0]  hsize, sc;
    logic [4:0]  mode, gain[4];
    logic [5:0]  ack_dly, cal;
    logic [7:0]  cmd_byte, rsp_byte, b2[4], b3[4], exp_q[$];
    logic [15:0] irq_val, acc, fa;
    logic [23:0] fb, fc;
    logic [31:0] haddr, hwdata, hrdata, ctl, rd_q[$], rm_q[$];
    logic [47:0] stamp;
    int          err_count, cmp_count;

    tcs_ctrl #(.TIME_RD_CMD(TRD)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ack(cmd_ack), .rsp_valid(rsp_valid),
        .rsp_byte(rsp_byte), .low_voltage_supply_on(low_voltage_supply_on), .bias_on(bias_on), .peer_unit_off(peer_unit_off));
    tcs_unit_model #(.TIME_CMD(TRD)) u_unit (
        .hclk(hclk), .hresetn(hresetn), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ack(cmd_ack),
        .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .ack_dly(ack_dly), .irq_val(irq_val), .stamp(stamp),
        .arg_bad(arg_bad));

    task automatic report_and_stop();
        if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic ahb(input logic w, input logic [31:0] a, d, e, m, output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        if (!w) begin
            rd_q.push_back(e);
            rm_q.push_back(m);
        end
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : ahb

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        ahb(1'b1, a, d, 32'h0000_0000, 32'h0000_0000, q);
    endtask : wr

    task automatic rd(input logic [31:0] a, e, m);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0000_0000, e, m, q);
    endtask : rd

    task automatic put(input logic [7:0] b[]);
        foreach (b[i]) exp_q.push_back(b[i]);
    endtask : put

    task automatic run(input int s);
        logic [31:0] q;
        logic [15:0] iv;
        logic [47:0] st;
        iv = 16'($urandom);
        st = {16'($urandom), 32'($urandom)};
        irq_val <= iv;
        stamp   <= st;
        ack_dly <= 6'($urandom % 4);
        case (s)
            0: put('{8'h41, 8'h85, 8'h89, 8'h8C, 8'h70});
            1, 2: begin
                for (int c = 2 * s - 2; c < 2 * s; c++) begin
                    put('{8'h90 + 8'(c), {3'h4, gain[c]}, b2[c], b3[c], 8'h32 + 8'(4 * c), 8'hA8 + 8'(c)});
                end
                put('{8'hD0, acc[15:8], acc[7:0], 8'h46 + 8'(2 * s), 8'h70});
            end
            3, 4: put('{8'h89, 8'h8B, 8'h70});
            5: put('{8'h88, 8'h84, 8'h40});
            6: put('{TRD});
            default: put('{8'h70});
        endcase
        wr(32'h0000_0000, ctl | 32'(s) | 32'h0000_0408);
        do ahb(1'b0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, q);
        while (q[0] !== 1'b0 || exp_q.size() != 0);
        if (s < 5 || s == 7) fa = ctl[7] ? (fa | iv) : iv;
        if (s == 1 || s == 2) sc = (s == 1) ? 3'h0 : 3'h4;
        if (s == 6 && ctl[8] && ctl[11] && !fbv) {fbv, fb} = {1'b1, st[47:24]};
        if (s == 6 && ctl[8] && ctl[12] && !fcv) {fcv, fc} = {1'b1, st[23:0]};
        rd(32'h0000_0020, {fa, fb[23:8]}, '1);
        rd(32'h0000_0024, {fb[7:0], fc}, '1);
        rd(32'h0000_0028, {sc, mode, 2'b00, cal, 16'h0000}, '1);
        rd(32'h0000_0000, {28'h000_0000, s == 5, !ctl[7], 2'b10}, 32'h0000_000F);
    endtask : run

    always @(posedge hclk) begin : mon
        logic [31:0] e, m;
        if (rd_ph && hreadyout === 1'b1) begin
            e = rd_q.pop_front();
            m = rm_q.pop_front();
            chk("hrdata", e & m, hrdata & m);
        end
        rd_ph = hsel && htrans[1] && !hwrite && hreadyout;
        if (cmd_valid && cmd_ack) chk("cmd_byte", exp_q.size() ? exp_q.pop_front() : 32'h0000_0100, cmd_byte);
    end

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    initial begin
        #400000;
        err_count++;
        report_and_stop();
    end

    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, peer_unit_off, ack_dly} = '0;
        {irq_val, stamp, ctl, fa, fb, fc, fbv, fcv, sc} = '0;
        hsize = 3'h2;
        void'($urandom(42));
        repeat (12) @(posedge hclk);
        chk("low_voltage_supply_on", 0, low_voltage_supply_on);
        chk("bias_on", 1, bias_on);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd(32'h0000_0000, 32'h0000_0000, 32'h0000_000F);
        wr(32'h0000_0040, 32'hFFFF_FFFF);
        rd(32'h0000_0040, 32'h0000_0000, '1);
        acc  = 16'($urandom);
        cal  = 6'($urandom);
        mode = 5'($urandom);
        wr(32'h0000_0004, {16'h0000, acc});
        wr(32'h0000_0018, {26'h000_0000, cal});
        wr(32'h0000_001C, {27'h000_0000, mode});
        for (int c = 0; c < 4; c++) begin
            {gain[c], b2[c], b3[c]} = 21'($urandom);
            wr(32'h0000_0008 + 32'(4 * c), {11'h000, gain[c], b2[c], b3[c]});
        end
        wr(32'h0000_0000, 32'h0000_0020);
        run(0);
        run(1);
        run(2);
        run(3);
        run(4);
        run(7);
        ctl = 32'h0000_0180;
        wr(32'h0000_0000, ctl | 32'h0000_0200);
        {fa, fb, fc} = '0;
        run(7);
        run(7);
        ctl = 32'h0000_1980;
        run(6);
        run(6);
        ctl = 32'h0000_1880;
        wr(32'h0000_0000, ctl | 32'h0000_0200);
        {fa, fb, fc, fbv, fcv} = '0;
        run(6);
        ctl = 32'h0000_0000;
        run(5);
        wr(32'h0000_0000, 32'h0000_0040);
        repeat (2) @(posedge hclk);
        chk("low_voltage_supply_on", 0, low_voltage_supply_on);
        wr(32'h0000_0000, 32'h0000_0020);
        ack_dly <= 6'd60;
        wr(32'h0000_0000, 32'h0000_000B);
        repeat (5) @(posedge hclk);
        chk("cmd_valid", 1, cmd_valid);
        wr(32'h0000_0000, 32'h0000_0010);
        repeat (2) @(posedge hclk);
        chk("low_voltage_supply_on", 0, low_voltage_supply_on);
        chk("bias_on", 1, bias_on);
        chk("cmd_valid", 0, cmd_valid);
        peer_unit_off <= 1'b1;
        wr(32'h0000_0000, 32'h0000_0020);
        wr(32'h0000_0000, 32'h0000_0010);
        repeat (2) @(posedge hclk);
        chk("bias_on", 0, bias_on);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("hreadyout", 0, hreadyout);
        chk("bias_on", 1, bias_on);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd(32'h0000_0000, 32'h0000_0000, 32'h0000_000F);
        chk("arg_bad", 0, arg_bad);
        report_and_stop();
    end
endmodule : tb_top

// >>> test/tcs_unit_model.sv
`timescale 1ns/1ps
module tcs_unit_model #(
    parameter logic [7:0] TIME_CMD = 8'h5A
) (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Command link.
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_byte,
    output logic             cmd_ack,
    output logic             rsp_valid,
    output logic      [7:0]  rsp_byte,
    // Bench knobs.
    input  wire logic [5:0]  ack_dly,
    input  wire logic [15:0] irq_val,
    input  wire logic [47:0] stamp,
    output logic             arg_bad
);
    logic [7:0] out_q[$];
    int         wait_n;
    int         arg_n;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_ack   <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_byte  <= 8'h00;
            arg_bad   <= 1'b0;
            out_q.delete();
            wait_n = 0;
            arg_n  = 0;
        end else begin
            cmd_ack   <= 1'b0;
            rsp_valid <= 1'b0;
            // The idle answer line toggles, so a stale byte never looks fresh.
            rsp_byte  <= ~rsp_byte;
            if (cmd_valid && cmd_ack) begin
                if (arg_n == 3 && cmd_byte[7:5] != 3'h4) arg_bad <= 1'b1;
                if (arg_n > 0) arg_n--;
                else if (cmd_byte[7:2] == 6'h24) arg_n = 3;
                else if (cmd_byte == 8'hD0) arg_n = 2;
                else if (cmd_byte == 8'h70) out_q = '{irq_val[15:8], irq_val[7:0]};
                else if (cmd_byte == TIME_CMD) for (int i = 5; i >= 0; i--) out_q.push_back(stamp[8*i +: 8]);
            end else if (out_q.size() > 0) begin
                rsp_valid <= 1'b1;
                rsp_byte  <= out_q.pop_front();
            end else if (!cmd_valid) begin
                wait_n = 0;
            end else if (wait_n >= ack_dly) begin
                cmd_ack <= 1'b1;
                wait_n = 0;
            end else begin
                wait_n++;
            end
        end
    end
endmodule : tcs_unit_model
